// *** include/pwmdpu_defs.vh ***
// Register map, field layout, reset values and channel defaults of the pulse-width stage.
`ifndef PWMDPU_DEFS_VH
`define PWMDPU_DEFS_VH

// Channel count and address layout: each channel owns a 16-byte window.
`define PWMDPU_NCH          4
`define PWMDPU_ADDR_W       8
`define PWMDPU_CH_STRIDE_SH 4

// Register word index inside a channel window (byte offset = index * 4).
`define PWMDPU_REG_CFG      2'h0
`define PWMDPU_REG_DUTY     2'h1
`define PWMDPU_REG_PERDUTY  2'h2
`define PWMDPU_REG_STATUS   2'h3

// Byte offsets inside a channel window.
`define PWMDPU_OFS_CFG      8'h00
`define PWMDPU_OFS_DUTY     8'h04
`define PWMDPU_OFS_PERDUTY  8'h08
`define PWMDPU_OFS_STATUS   8'h0c

// Configuration register fields.
`define PWMDPU_CFG_W        5
`define PWMDPU_CFG_CLS_LSB  0
`define PWMDPU_CFG_CLS_MSB  1
`define PWMDPU_CFG_POL_BIT  2
`define PWMDPU_CFG_DEND_BIT 3
`define PWMDPU_CFG_PEND_BIT 4

// Channel classes.
`define PWMDPU_CLASS_FIXED  2'h0
`define PWMDPU_CLASS_SHIFT  2'h1
`define PWMDPU_CLASS_VAR    2'h2

// Configuration reset value: variable period, active high, immediate updates.
`define PWMDPU_CFG_RST      5'h06

// Duty code scale: full scale means 100 percent.
`define PWMDPU_DUTY_W       16
`define PWMDPU_DUTY_FULL    16'h8000
`define PWMDPU_DUTY_SH      15

// Channel defaults after reset, in clock ticks and duty code.
`define PWMDPU_PER_W        16
`define PWMDPU_DEF_PERIOD   16'h0064
`define PWMDPU_DEF_DUTY     16'h4000

// Status register fields.
`define PWMDPU_ST_ACT_BIT   0
`define PWMDPU_ST_OUT_BIT   1
`define PWMDPU_ST_DPND_BIT  2
`define PWMDPU_ST_PPND_BIT  3

`endif

// *** hw/pwmdpu_ahb.v ***
// AHB-Lite slave front end: zero-wait single-word register access.
`timescale 1ns/1ps
module pwmdpu_ahb #(
  parameter ADDR_W = 8
) (
  // Clock and reset.
  input  wire              clk_i,
  input  wire              rstn_i,
  // AHB-Lite slave side.
  input  wire              hsel_i,
  input  wire [ADDR_W-1:0] haddr_i,
  input  wire [1:0]        htrans_i,
  input  wire              hwrite_i,
  input  wire [2:0]        hsize_i,
  input  wire [31:0]       hwdata_i,
  input  wire              hready_i,
  output reg               hreadyout_o,
  output reg               hresp_o,
  output reg  [31:0]       hrdata_o,
  // Register file side.
  input  wire [31:0]       rdata_i,
  output reg               wr_en_o,
  output reg  [ADDR_W-1:0] wr_addr_o,
  output reg  [31:0]       wr_data_o
);

  wire take = hsel_i & htrans_i[1] & hready_i;
  wire word = (hsize_i == 3'h2);

  reg              wpend_r;
  reg [ADDR_W-1:0] waddr_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Address phase capture; read data is registered so it stands in the data phase.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wpend_r     <= 1'b0;
      waddr_r     <= {ADDR_W{1'b0}};
      hrdata_o    <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      wpend_r     <= take & hwrite_i & word;
      if (take) begin
        waddr_r <= haddr_i;
      end
      hrdata_o <= (take & ~hwrite_i) ? rdata_i : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data phase: write data is taken at the edge that ends it.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_en_o   <= 1'b0;
      wr_addr_o <= {ADDR_W{1'b0}};
      wr_data_o <= 32'h0;
    end else begin
      wr_en_o <= wpend_r & hready_i;
      if (wpend_r & hready_i) begin
        wr_addr_o <= waddr_r;
        wr_data_o <= hwdata_i;
      end
    end
  end

endmodule

// *** hw/pwmdpu_top.v ***
// Multi-channel pulse-width output stage with run-time duty and period updates.
//
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "pwmdpu_defs.vh"
module pwmdpu_top #(
  parameter NCH        = `PWMDPU_NCH,
  parameter ADDR_W     = `PWMDPU_ADDR_W,
  parameter DEF_PERIOD = `PWMDPU_DEF_PERIOD,
  parameter DEF_DUTY   = `PWMDPU_DEF_DUTY
) (
  // Clock and reset.
  input  wire              clk_i,
  input  wire              rstn_i,
  // AHB-Lite register bus.
  input  wire              hsel_i,
  input  wire [ADDR_W-1:0] haddr_i,
  input  wire [1:0]        htrans_i,
  input  wire              hwrite_i,
  input  wire [2:0]        hsize_i,
  input  wire [31:0]       hwdata_i,
  input  wire              hready_i,
  output wire              hreadyout_o,
  output wire              hresp_o,
  output wire [31:0]       hrdata_o,
  // Modulated outputs, one per channel.
  output wire [NCH-1:0]    pwm_o
);

  localparam DW   = `PWMDPU_DUTY_W;
  localparam PW   = `PWMDPU_PER_W;
  localparam CW   = `PWMDPU_CFG_W;
  localparam SH   = `PWMDPU_CH_STRIDE_SH;
  localparam IW   = ADDR_W - SH;
  localparam [PW-1:0] DEF_PER_C  = DEF_PERIOD[PW-1:0];
  localparam [DW-1:0] DEF_DUTY_C = DEF_DUTY[DW-1:0];
  localparam [DW-1:0] FULL       = `PWMDPU_DUTY_FULL;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus front end.

  wire              wr_en_w;
  wire [ADDR_W-1:0] wr_addr_w;
  wire [31:0]       wr_data_w;
  reg  [31:0]       rdata_w;

  pwmdpu_ahb #(
    .ADDR_W (ADDR_W)
  ) u_ahb (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hsize_i     (hsize_i),
    .hwdata_i    (hwdata_i),
    .hready_i    (hready_i),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .hrdata_o    (hrdata_o),
    .rdata_i     (rdata_w),
    .wr_en_o     (wr_en_w),
    .wr_addr_o   (wr_addr_w),
    .wr_data_o   (wr_data_w)
  );

  // Write decode shared by all channels.
  wire [IW-1:0] wr_ch_w  = wr_addr_w[ADDR_W-1:SH];
  wire [1:0]    wr_reg_w = wr_addr_w[3:2];

  // Out-of-range duty codes are clipped to full scale.
  wire [DW-1:0] wr_duty_w = (wr_data_w[DW-1:0] > FULL) ? FULL : wr_data_w[DW-1:0];
  wire [PW-1:0] wr_per_w  = wr_data_w[31:16];

  // Per-channel state gathered flat for the read mux.
  wire [CW*NCH-1:0] cfg_all;
  wire [DW*NCH-1:0] duty_all;
  wire [PW*NCH-1:0] per_all;
  wire [4*NCH-1:0]  st_all;

  ////////////////////////////////////////////////////////////////////////////////
  // Channels.

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      localparam integer  GI  = g;
      localparam [IW-1:0] IDX = GI[IW-1:0];

      reg  [CW-1:0] cfg_r;
      reg  [PW-1:0] period_r;
      reg  [DW-1:0] duty_r;
      reg  [PW-1:0] pend_per_r;
      reg  [DW-1:0] pend_duty_r;
      reg           pend_pv_r;
      reg           pend_dv_r;
      reg  [PW-1:0] cnt_r;
      reg           act_r;
      reg           out_r;
      reg           act_nxt;
      reg  [PW-1:0] period_nxt;
      reg  [DW-1:0] duty_nxt;
      reg  [PW-1:0] pend_per_nxt;
      reg  [DW-1:0] pend_duty_nxt;
      reg           pend_pv_nxt;
      reg           pend_dv_nxt;

      // Write strobes for this channel only.
      wire hit      = wr_en_w & (wr_ch_w == IDX);
      wire wr_cfg   = hit & (wr_reg_w == `PWMDPU_REG_CFG);
      wire wr_duty  = hit & (wr_reg_w == `PWMDPU_REG_DUTY);
      wire wr_pd    = hit & (wr_reg_w == `PWMDPU_REG_PERDUTY);

      wire [1:0] cls   = cfg_r[`PWMDPU_CFG_CLS_MSB:`PWMDPU_CFG_CLS_LSB];
      wire       pol   = cfg_r[`PWMDPU_CFG_POL_BIT];
      wire       d_end = cfg_r[`PWMDPU_CFG_DEND_BIT];
      wire       p_end = cfg_r[`PWMDPU_CFG_PEND_BIT];
      wire       var_c = (cls == `PWMDPU_CLASS_VAR);

      wire [PW+DW-1:0] prod = period_r * duty_r;
      wire [PW-1:0]    hi   = prod[PW+`PWMDPU_DUTY_SH-1:`PWMDPU_DUTY_SH];

      // Boundary when the last tick of the period is reached; a zero period is
      // a boundary on every tick so pending values never get stuck.
      wire [PW:0] cnt_inc = {1'b0, cnt_r} + {{PW{1'b0}}, 1'b1};
      wire        bnd     = (cnt_inc >= {1'b0, period_r});

      // combined write takes the period only on the variable class.
      wire pd_per  = wr_pd & var_c;
      wire pd_only = wr_pd & ~var_c;

      // Output may only go active at a period start and only go inactive once the active
      // phase has run out, so a mid-period change cannot cut a spike.
      // glitch-free duty
      always @* begin
        if (cnt_r == {PW{1'b0}}) begin
          act_nxt = (hi != {PW{1'b0}});
        end else begin
          act_nxt = act_r & (cnt_r < hi);
        end
      end

      // Configuration register per channel.
      // class select
      always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          cfg_r <= `PWMDPU_CFG_RST;
        end else if (wr_cfg) begin
          cfg_r <= wr_data_w[CW-1:0];
        end
      end

      // Counter and output.
      // modulation
      always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          cnt_r <= {PW{1'b0}};
          act_r <= 1'b0;
          out_r <= 1'b0;
        end else begin
          cnt_r <= bnd ? {PW{1'b0}} : cnt_inc[PW-1:0];
          act_r <= act_nxt;
          out_r <= act_nxt ? pol : ~pol;
        end
      end

      // Next applied and pending values. A pending value moves over at the
      // boundary first; a deferred write in that same cycle lands after it and stays pending.
      always @* begin
        period_nxt    = period_r;
        duty_nxt      = duty_r;
        pend_per_nxt  = pend_per_r;
        pend_duty_nxt = pend_duty_r;
        pend_pv_nxt   = pend_pv_r;
        pend_dv_nxt   = pend_dv_r;
        if (bnd & pend_dv_r) begin
          duty_nxt    = pend_duty_r;
          pend_dv_nxt = 1'b0;
        end
        if (bnd & pend_pv_r) begin
          period_nxt  = pend_per_r;
          pend_pv_nxt = 1'b0;
        end
        if (wr_duty | pd_only) begin
          if (d_end) begin
            pend_duty_nxt = wr_duty_w;
            pend_dv_nxt   = 1'b1;
          end else begin
            duty_nxt = wr_duty_w;
          end
        end
        if (pd_per) begin
          if (p_end | d_end) begin
            pend_per_nxt  = wr_per_w;
            pend_duty_nxt = wr_duty_w;
            pend_pv_nxt   = 1'b1;
            pend_dv_nxt   = 1'b1;
          end else begin
            period_nxt = wr_per_w;
            duty_nxt   = wr_duty_w;
          end
        end
      end

      // Applied and pending values.
      always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          period_r    <= DEF_PER_C;
          duty_r      <= DEF_DUTY_C;
          pend_per_r  <= DEF_PER_C;
          pend_duty_r <= DEF_DUTY_C;
          pend_pv_r   <= 1'b0;
          pend_dv_r   <= 1'b0;
        end else begin
          period_r    <= period_nxt;
          duty_r      <= duty_nxt;
          pend_per_r  <= pend_per_nxt;
          pend_duty_r <= pend_duty_nxt;
          pend_pv_r   <= pend_pv_nxt;
          pend_dv_r   <= pend_dv_nxt;
        end
      end

      // Status word, each flag at its defined bit position.
      wire [3:0] st_w;
      assign st_w[`PWMDPU_ST_ACT_BIT]  = act_r;
      assign st_w[`PWMDPU_ST_OUT_BIT]  = out_r;
      assign st_w[`PWMDPU_ST_DPND_BIT] = pend_dv_r;
      assign st_w[`PWMDPU_ST_PPND_BIT] = pend_pv_r;

      assign pwm_o[g]                = out_r;
      assign cfg_all[g*CW +: CW]     = cfg_r;
      assign duty_all[g*DW +: DW]    = duty_r;
      assign per_all[g*PW +: PW]     = period_r;
      assign st_all[g*4 +: 4]        = st_w;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux, addressed straight from the address phase.

  wire [IW-1:0] rd_ch_w  = haddr_i[ADDR_W-1:SH];
  wire [1:0]    rd_reg_w = haddr_i[3:2];
  wire          rd_hit_w = (rd_ch_w < NCH);

  always @* begin
    rdata_w = 32'h0;
    if (rd_hit_w) begin
      case (rd_reg_w)
        `PWMDPU_REG_CFG: begin
          rdata_w[CW-1:0] = cfg_all[rd_ch_w*CW +: CW];
        end
        `PWMDPU_REG_DUTY: begin
          rdata_w[DW-1:0] = duty_all[rd_ch_w*DW +: DW];
        end
        `PWMDPU_REG_PERDUTY: begin
          rdata_w = {per_all[rd_ch_w*PW +: PW], duty_all[rd_ch_w*DW +: DW]};
        end
        `PWMDPU_REG_STATUS: begin
          rdata_w[3:0] = st_all[rd_ch_w*4 +: 4];
        end
        default: begin
          rdata_w = 32'h0;
        end
      endcase
    end
  end

endmodule

// *** verification/pwmdpu_props.sv ***
// Port checker for the pulse-width stage, bound to its top module.
`timescale 1ns/1ps
module pwmdpu_props #(
  parameter NCH        = 4,
  parameter ADDR_W     = 8,
  parameter DEF_PERIOD = 8,
  parameter DEF_DUTY   = 16'h4000
) (
  // Clock and reset.
  input wire              clk_i,
  input wire              rstn_i,
  // Register bus.
  input wire              hsel_i,
  input wire [ADDR_W-1:0] haddr_i,
  input wire [1:0]        htrans_i,
  input wire              hwrite_i,
  input wire [2:0]        hsize_i,
  input wire [31:0]       hwdata_i,
  input wire              hready_i,
  input wire              hreadyout_o,
  input wire              hresp_o,
  input wire [31:0]       hrdata_o,
  // Outputs.
  input wire [NCH-1:0]    pwm_o
);
  reg              aw_v_r;
  reg              ar_v_r;
  reg [ADDR_W-1:0] aw_a_r;
  reg [4:0]        cfg_r;
  reg [15:0]       per_r;
  reg [15:0]       dty_r;
  reg [15:0]       run_r;
  reg [5:0]        age_r;
  reg [3:0]        cyc_r;
  wire             tk  = hsel_i & htrans_i[1] & hready_i;
  wire             pol = cfg_r[2];
  wire             act = pwm_o[0] ~^ pol;
  wire             dw  = aw_v_r && aw_a_r == 8'h04;
  wire             pw  = aw_v_r && aw_a_r == 8'h08;
  wire [15:0]      dcl = (dty_r > 16'h8000) ? 16'h8000 : dty_r;
  wire [31:0]      hi  = ({16'h0000, per_r} * {16'h0000, dcl}) >> 15;

  ////////////////////////////////////////////////////////////////////////////
  // Shadow of channel 0 settings, taken from the bus data phases.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_v_r <= 1'b0;
      ar_v_r <= 1'b0;
      aw_a_r <= {ADDR_W{1'b0}};
      cfg_r  <= 5'h06;
      per_r  <= DEF_PERIOD;
      dty_r  <= DEF_DUTY;
      run_r  <= 16'h0000;
      age_r  <= 6'h00;
      cyc_r  <= 4'h0;
    end else begin
      aw_v_r <= tk & hwrite_i & (hsize_i == 3'h2);
      ar_v_r <= tk & ~hwrite_i;
      aw_a_r <= haddr_i;
      cyc_r  <= (cyc_r == 4'hf) ? cyc_r : cyc_r + 4'h1;
      age_r  <= (age_r == 6'h3f) ? age_r : age_r + 6'h01;
      run_r  <= act ? run_r + 16'h0001 : 16'h0000;
      if (aw_v_r && aw_a_r[7:4] == 4'h0 && aw_a_r[3:0] != 4'hc) begin
        age_r <= 6'h00;
        if (aw_a_r[3:0] == 4'h0) begin
          cfg_r <= hwdata_i[4:0];
        end else begin
          dty_r <= hwdata_i[15:0];
        end
        if (aw_a_r[3:0] == 4'h8 && cfg_r[1:0] == 2'h2) begin
          per_r <= hwdata_i[31:16];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  AST_READY_HIGH: assert property (hreadyout_o)
    else $error("bus ready dropped");
  AST_RESP_OKAY: assert property (!hresp_o)
    else $error("bus response not okay");
  AST_RDATA_IDLE: assert property (!ar_v_r |-> hrdata_o == 32'h0)
    else $error("read data outside a read");
  // The first period assumes a default period of 8 and half duty.
  AST_DEFAULT_WAVE: assert property (cyc_r == 4'h1 |-> (&pwm_o)[*4] ##1
    (pwm_o == {NCH{1'b0}})[*4] ##1 (&pwm_o)) else $error("default waveform wrong");
  AST_ZERO_DUTY: assert property (dw && hwdata_i[15:0] == 16'h0 |->
    ##[1:12] (pwm_o[0] != pol)[*8]) else $error("zero duty not static");
  AST_FULL_DUTY: assert property (dw && hwdata_i[15:0] >= 16'h8000 |->
    ##[1:12] (pwm_o[0] == pol)[*8]) else $error("full duty not static");
  AST_ZERO_PERIOD: assert property (pw && hwdata_i[31:16] == 16'h0 && cfg_r[1:0] == 2'h2
    |-> ##[1:12] (pwm_o[0] != pol)[*8]) else $error("zero period not inactive");
  AST_ACTIVE_LEN: assert property (!act && run_r != 16'h0 && age_r == 6'h3f
    |-> run_r == hi[15:0]) else $error("active phase length wrong");
  COV_ZERO: cover property (dw && hwdata_i[15:0] == 16'h0);
  COV_LEN: cover property (!act && run_r != 16'h0 && age_r == 6'h3f);
  COV_PER0: cover property (pw && hwdata_i[31:16] == 16'h0);
endmodule

bind pwmdpu_top pwmdpu_props #(.NCH(NCH), .ADDR_W(ADDR_W), .DEF_PERIOD(DEF_PERIOD),
  .DEF_DUTY(DEF_DUTY)) i_pwmdpu_props (.clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
  .hwdata_i(hwdata_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .hrdata_o(hrdata_o), .pwm_o(pwm_o));

// *** verification/pwmdpu_host.sv ***
// Bus master model standing in for the host processor.
`timescale 1ns/1ps
module pwmdpu_host (
  // Clock.
  input  wire         clk_i,
  // Master request.
  output logic        hsel_o,
  output logic [7:0]  haddr_o,
  output logic [1:0]  htrans_o,
  output logic        hwrite_o,
  output logic [2:0]  hsize_o,
  output logic [31:0] hwdata_o,
  // Slave answer.
  input  wire         hready_i,
  input  wire  [31:0] hrdata_i
);
  initial begin
    hsel_o = 1'b0;
    haddr_o = 8'h00;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
  end

  // code and period travel whole in one word.
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
    @(posedge clk_i);
    hsel_o <= 1'b1;
    haddr_o <= a;
    htrans_o <= 2'h2;
    hwrite_o <= w;
    hwdata_o <= ~hwdata_o;
    @(posedge clk_i);
    while (hready_i !== 1'b1) @(posedge clk_i);
    htrans_o <= 2'h0;
    hwdata_o <= wd;
    @(posedge clk_i);
    while (hready_i !== 1'b1) @(posedge clk_i);
    rd = hrdata_i;
  endtask
endmodule

// *** verification/pwm_duty_period_update_bench.sv ***
// Self-checking bench for the pulse-width stage.
`timescale 1ns/1ps
module pwm_duty_period_update_bench;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  wire         hsel, hwrite, hready, hresp;
  wire [7:0]   haddr;
  wire [1:0]   htrans;
  wire [2:0]   hsize;
  wire [31:0]  hwdata, hrdata;
  wire [3:0]   pwm;
  int          mismatches = 0;
  int          n_checks = 0;
  logic [31:0] rdv;

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  pwmdpu_top #(.DEF_PERIOD(8)) i_pwmdpu_top (.clk_i(clk_i), .rstn_i(rstn_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
    .hresp_o(hresp), .hrdata_o(hrdata), .pwm_o(pwm));
  pwmdpu_host i_pwmdpu_host (.clk_i(clk_i), .hsel_o(hsel), .haddr_o(haddr),
    .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata),
    .hready_i(hready), .hrdata_i(hrdata));

  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    i_pwmdpu_host.xfer(1'b1, a, d, rdv);
  endtask

  task rd(input logic [7:0] a);
    i_pwmdpu_host.xfer(1'b0, a, 32'h0, rdv);
  endtask

  // Counts active cycles of channel 0 and high cycles of channel 1.
  task meas(input logic p, input int n, output int c0, output int c1);
    c0 = 0;
    c1 = 0;
    repeat (n) begin
      @(posedge clk_i);
      c0 += (pwm[0] === p);
      c1 += (pwm[1] === 1'b1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    repeat (12) @(posedge clk_i);
    rd(8'h04);
    chk("duty reset", rdv, 32'h4000);
    rd(8'h08);
    chk("perduty reset", rdv, 32'h00084000);
    rd(8'h00);
    chk("cfg reset", rdv, 32'h6);
    wr(8'h44, 32'h1234);
    rd(8'h44);
    chk("unmapped", rdv, 32'h0);
  endtask

  task t_duty;
    logic [15:0] tab [5] = '{16'h0000, 16'h1000, 16'h6000, 16'h8000, 16'h9000};
    int c0, c1, e;
    for (int p = 1; p >= 0; p--) begin
      wr(8'h00, {27'h0, p[0], 2'h2});
      for (int i = 0; i < 5; i++) begin
        wr(8'h04, {16'h0, tab[i]});
        repeat (64) @(posedge clk_i);
        e = ((tab[i] > 16'h8000) ? 32'h8000 : {16'h0, tab[i]}) * 8 >> 15;
        meas(p[0], 16, c0, c1);
        chk("ch0 active", c0, 2 * e);
        chk("ch1 high", c1, 8);
      end
    end
    rd(8'h04);
    chk("duty clip", rdv, 32'h8000);
  endtask

  task t_perduty;
    int c0, c1;
    wr(8'h00, 32'h6);
    wr(8'h08, 32'h000c2000);
    repeat (30) @(posedge clk_i);
    meas(1'b1, 24, c0, c1);
    chk("new period", c0, 6);
    rd(8'h08);
    chk("perduty", rdv, 32'h000c2000);
    wr(8'h20, 32'h4);
    wr(8'h28, 32'h00102000);
    rd(8'h28);
    chk("fixed period", rdv, 32'h00082000);
    wr(8'h08, 32'h00004000);
    repeat (20) @(posedge clk_i);
    meas(1'b1, 16, c0, c1);
    chk("zero period", c0, 0);
  endtask

  task t_defer;
    wr(8'h30, 32'h1e);
    wait (pwm[3] === 1'b0);
    wait (pwm[3] === 1'b1);
    wr(8'h38, 32'h00104000);
    rd(8'h3c);
    chk("both pending", rdv[3:2], 32'h3);
    repeat (40) @(posedge clk_i);
    rd(8'h38);
    chk("period loaded", rdv, 32'h00104000);
    wait (pwm[3] === 1'b0);
    wait (pwm[3] === 1'b1);
    wr(8'h34, 32'h8000);
    rd(8'h3c);
    chk("duty pending", rdv[3:2], 32'h1);
    repeat (40) @(posedge clk_i);
    rd(8'h3c);
    chk("none pending", rdv[3:2], 32'h0);
  endtask

  // Counts rises of channel 1 and the length of its first whole high run.
  task runs(input int n, output int rises, output int first);
    int   len;
    logic prev;
    rises = 0;
    first = 0;
    len = 0;
    prev = pwm[1];
    repeat (n) begin
      @(posedge clk_i);
      if (pwm[1] === 1'b1 && prev !== 1'b1) begin
        rises++;
        len = 0;
      end
      if (pwm[1] === 1'b1) begin
        len++;
      end else if (prev === 1'b1 && rises > 0 && first == 0) begin
        first = len;
      end
      prev = pwm[1];
    end
  endtask

  // Grows the duty in the idle part of a period: no extra pulse may appear there.
  task t_spike;
    int r, f;
    wr(8'h14, 32'h1000);
    repeat (16) @(posedge clk_i);
    wait (pwm[1] === 1'b0);
    wait (pwm[1] === 1'b1);
    wait (pwm[1] === 1'b0);
    wr(8'h14, 32'h7000);
    runs(16, r, f);
    chk("spike rises", r, 2);
    chk("first new pulse", f, 7);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    end_sim;
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_regs;
    t_duty;
    t_perduty;
    t_defer;
    t_spike;
    end_sim;
  end
endmodule
